// *** rtl/afe_pin_regs.svh ***
// constants for the analog front end pin interface
// Function
// - low done pulse after every conversion
// - done idles high or floats per select
// - pulse half sample period, repeats at rate
// - done pulses regardless of serial activity
// - two-wire: done and clock pins are gain straps
// - straps sampled on two-wire entry and watchdog
// - external clock: crystal return pin selects mode
// - mode captured after any reset, then held
// - external clock disables the crystal oscillator
// - chip select frames transfers; high ignores traffic
// - master reset low blocks all transactions
// - sample input on rise, drive output on fall
// - serial clock may idle low or high
// - data out floats except during read data or a two-wire frame
// - two-wire sends one frame per data ready
// - command is read or write; reads ignore input
// - bitstream output enabled disables done output
// - master reset idles serial port, clears dividers and buffer
// - two-wire: master reset pin is ratio strap
`ifndef AFE_PIN_REGS_SVH
`define AFE_PIN_REGS_SVH
`define AFE_CMD_W 8
`define AFE_WORD_W 24
`define AFE_READ_BIT 0
`define AFE_SAMPLE_DIV 4
`define AFE_OSR_MIN 32
`define AFE_SYNC_N 7
`define AFE_STRAP_RST 5'h00
`define AFE_MODE_RST 1'h0
`endif

// *** rtl/afe_pin_pkg.sv ***
// types shared by the analog front end pin interface
package afe_pin_pkg;
  typedef enum {AFE_MODE_SPI, AFE_MODE_TWO} afe_mode_t;
  typedef enum {ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_FRAME} afe_st_t;
endpackage : afe_pin_pkg

// *** rtl/afe_fifo2.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module afe_fifo2 #(
  parameter int W = 24
) (
  input wire logic mclk, // clock
  input wire logic nrst, // async reset, active low
  input wire logic clr, // synchronous flush
  input wire logic in_valid, // writer offers a word
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes a word
  output logic [W-1:0] out_data // oldest word
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  // full and empty come straight from the count
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (clr) begin
      wp_d = 1'b0;
      rp_d = 1'b0;
      cnt_d = 2'h0;
    end else begin
      if (push) begin
        mem_d[wp_q] = in_data;
        wp_d = ~wp_q;
      end
      if (pop) begin
        rp_d = ~rp_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_FIFO_NO_OVER: assert property (cnt_q <= 2'h2)
    else $error("buffer count beyond two");
endmodule : afe_fifo2
`default_nettype wire

// *** rtl/afe_pin_if.sv ***
// pin-level digital interface: done pulse, mode, straps, serial port
`timescale 1ns/1ps
`default_nettype none
`include "afe_pin_regs.svh"
module afe_pin_if
  import afe_pin_pkg::*;
#(
  parameter int WORD_W = `AFE_WORD_W
) (
  input wire logic mclk, // master clock, 40 MHz
  input wire logic nrst, // power-on reset, active low
  input wire logic mreset_pin, // master reset / ratio strap lo pin
  input wire logic sck_pin, // serial clock pin
  input wire logic cs_n_pin, // chip select / bias strap pin
  input wire logic sdi_pin, // data in / ratio strap hi pin
  output logic sdo_o, // data out level
  output logic sdo_oe, // data out enable
  input wire logic done_pin_i, // done pin read back (gain hi strap)
  output logic conversion_done_n, // done pin level, active low
  output logic conversion_done_oe, // done pin enable
  input wire logic clock_input_pin, // clock input pin level (gain lo)
  input wire logic crystal_return_pin, // mode select pin
  input wire logic external_clock_sel, // 1: external clock
  output logic osc_enable, // crystal oscillator enable
  input wire logic done_idle_drive_sel, // 1: done idles driven high
  input wire logic bitstream_out_enable, // modulator output enabled
  input wire logic wdt_reset, // watchdog reset pulse
  input wire logic [1:0] pre_sel, // prescale 1,2,4,8
  input wire logic [2:0] osr_sel, // ratio 32 << osr_sel
  input wire logic res_valid, // conversion result offered
  output logic res_ready, // buffer has room
  input wire logic [WORD_W-1:0] res_data, // conversion result
  output logic conv_evt, // one-cycle end of conversion
  output logic [`AFE_CMD_W-1:0] cmd_q, // last command byte
  output logic cmd_valid, // one-cycle command taken
  output logic [7:0] wr_byte_q, // written data byte
  output logic wr_byte_valid, // one-cycle byte taken
  output logic two_wire_mode, // captured interface mode
  output logic gain_strap_hi, // latched strap
  output logic gain_strap_lo, // latched strap
  output logic bias_strap_a, // latched strap
  output logic ratio_strap_hi, // latched strap
  output logic ratio_strap_lo // latched strap
);
  localparam int SN = `AFE_SYNC_N;
  localparam int BW = $clog2(WORD_W + 1);

  // two-stage synchronisers for every pin input
  logic [SN-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {mreset_pin, sck_pin, cs_n_pin, sdi_pin, done_pin_i,
                    clock_input_pin, crystal_return_pin};
  genvar gi;
  generate
    for (gi = 0; gi < SN; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  logic s_mrst, s_sck, s_cs_n, s_sdi, s_done, s_clki, s_mode;
  assign {s_mrst, s_sck, s_cs_n, s_sdi, s_done, s_clki, s_mode} = sync2_q;

  // mode capture and straps
  logic mode_q, mode_d, mode_prev_q;
  logic [2:0] cap_pend_q, cap_pend_d;
  logic [4:0] strap_q, strap_d;
  logic mode_cap, strap_cap, spi, hold;
  assign spi = (mode_q == 1'b0);
  assign hold = spi && !s_mrst;
  // capture waits two edges so the synchronisers hold the real pin level
  assign mode_cap = (cap_pend_q == 3'h1) || wdt_reset || hold;
  assign strap_cap = !spi && (!mode_prev_q || wdt_reset);

  always_comb begin
    cap_pend_d = {1'b0, cap_pend_q[2:1]};
    mode_d = mode_q;
    strap_d = strap_q;
    if (mode_cap) begin
      mode_d = external_clock_sel && s_mode;
    end
    if (strap_cap) begin
      // gain from done and clock pins, ratio lo from reset pin
      strap_d = {s_done, s_clki, s_cs_n, s_sdi, s_mrst};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap_pend_q <= 3'h7;
      mode_q <= `AFE_MODE_RST;
      mode_prev_q <= `AFE_MODE_RST;
      strap_q <= `AFE_STRAP_RST;
    end else begin
      cap_pend_q <= cap_pend_d;
      mode_q <= mode_d;
      mode_prev_q <= !spi;
      strap_q <= strap_d;
    end
  end
  assign two_wire_mode = mode_q;
  assign {gain_strap_hi, gain_strap_lo, bias_strap_a, ratio_strap_hi,
          ratio_strap_lo} = strap_q;
  assign osc_enable = !external_clock_sel;

  // rate dividers: sample tick, conversion tick, half-sample pulse
  logic [5:0] div_q, div_d, div_top;
  logic [11:0] osr_q, osr_d, osr_top;
  logic [4:0] pw_q, pw_d;
  logic done_n_q, done_n_d, dm_tick, evt_q, evt_d;
  assign div_top = 6'(`AFE_SAMPLE_DIV << pre_sel) - 6'h01;
  assign osr_top = 12'(`AFE_OSR_MIN << osr_sel) - 12'h001;
  assign dm_tick = (div_q >= div_top);

  // runs with no regard to the serial port; only reset stops it
  always_comb begin
    div_d = dm_tick ? 6'h00 : div_q + 6'h01;
    osr_d = osr_q;
    evt_d = 1'b0;
    pw_d = (pw_q != 5'h00) ? pw_q - 5'h01 : 5'h00;
    if (dm_tick) begin
      if (osr_q >= osr_top) begin
        osr_d = 12'h000;
        evt_d = 1'b1;
        pw_d = 5'(2 << pre_sel);
      end else begin
        osr_d = osr_q + 12'h001;
      end
    end
    if (hold) begin
      div_d = 6'h00;
      osr_d = 12'h000;
      pw_d = 5'h00;
      evt_d = 1'b0;
    end
    done_n_d = (pw_d == 5'h00);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 6'h00;
      osr_q <= 12'h000;
      pw_q <= 5'h00;
      done_n_q <= 1'b1;
      evt_q <= 1'b0;
    end else begin
      div_q <= div_d;
      osr_q <= osr_d;
      pw_q <= pw_d;
      done_n_q <= done_n_d;
      evt_q <= evt_d;
    end
  end
  assign conv_evt = evt_q;
  assign conversion_done_n = done_n_q;
  // pin belongs to the strap in two-wire mode; idle drive per select
  assign conversion_done_oe = spi && !bitstream_out_enable &&
                              (!done_n_q || done_idle_drive_sel);

  // result buffer between converter and serial port
  logic pop;
  logic buf_valid;
  logic [WORD_W-1:0] buf_data;
  afe_fifo2 #(.W(WORD_W)) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .clr(hold),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  // serial engine, sck edges seen through the synchroniser
  afe_st_t st_q, st_d;
  logic sck_prev_q, rise, fall, cs_act;
  logic [BW-1:0] bit_q, bit_d;
  logic [WORD_W-1:0] sh_q, sh_d;
  logic [`AFE_CMD_W-1:0] cmd_d;
  logic [7:0] wb_d;
  logic sdo_q, sdo_d, cmdv_d, cmdv_q, wbv_d, wbv_q;
  // both idle levels work since only edges are used
  assign rise = s_sck && !sck_prev_q;
  assign fall = !s_sck && sck_prev_q;
  assign cs_act = spi && !s_cs_n && s_mrst;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    wb_d = wr_byte_q;
    sdo_d = sdo_q;
    cmdv_d = 1'b0;
    wbv_d = 1'b0;
    pop = 1'b0;
    case (st_q)
      ST_IDLE: begin
        bit_d = '0;
        if (!spi && evt_q) begin
          st_d = ST_FRAME;
          sh_d = buf_valid ? buf_data : '0;
          pop = buf_valid;
          bit_d = BW'(WORD_W);
        end else if (cs_act) begin
          st_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rise) begin
          cmd_d = {cmd_q[`AFE_CMD_W-2:0], s_sdi};
          bit_d = bit_q + BW'(1);
          if (bit_q == BW'(`AFE_CMD_W - 1)) begin
            cmdv_d = 1'b1;
            bit_d = '0;
            if (s_sdi == 1'b1 && `AFE_READ_BIT == 0) begin
              st_d = ST_READ;
              sh_d = buf_valid ? buf_data : '0;
              pop = buf_valid;
            end else begin
              st_d = ST_WRITE;
            end
          end
        end
      end
      ST_READ: begin
        if (fall) begin
          // sdi is not looked at while reading
          sdo_d = sh_q[WORD_W-1];
          sh_d = {sh_q[WORD_W-2:0], 1'b0};
          bit_d = bit_q + BW'(1);
          if (bit_q == BW'(WORD_W - 1)) begin
            bit_d = '0;
            sh_d = buf_valid ? buf_data : '0;
            pop = buf_valid;
          end
        end
      end
      ST_WRITE: begin
        if (rise) begin
          wb_d = {wr_byte_q[6:0], s_sdi};
          bit_d = (bit_q == BW'(7)) ? '0 : bit_q + BW'(1);
          wbv_d = (bit_q == BW'(7));
        end
      end
      ST_FRAME: begin
        // clock pin is the master clock here, one bit per cycle
        sdo_d = sh_q[WORD_W-1];
        sh_d = {sh_q[WORD_W-2:0], 1'b0};
        bit_d = bit_q - BW'(1);
        if (bit_q == '0) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (spi && st_q != ST_IDLE && !cs_act) begin
      st_d = ST_IDLE;
    end
    if (!spi && st_q != ST_IDLE && st_q != ST_FRAME) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      sck_prev_q <= 1'b1; // same as synchroniser reset, no false edge
      bit_q <= '0;
      sh_q <= '0;
      cmd_q <= '0;
      wr_byte_q <= 8'h00;
      sdo_q <= 1'b0;
      cmdv_q <= 1'b0;
      wbv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sck_prev_q <= s_sck;
      bit_q <= bit_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      wr_byte_q <= wb_d;
      sdo_q <= sdo_d;
      cmdv_q <= cmdv_d;
      wbv_q <= wbv_d;
    end
  end
  assign cmd_valid = cmdv_q;
  assign wr_byte_valid = wbv_q;
  assign sdo_o = sdo_q;
  // drives only in read data or a two-wire frame
  assign sdo_oe = (st_q == ST_READ && cs_act) ||
                  (st_q == ST_FRAME);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // half a sample period at prescale one; a master reset in the first
  // cycle cuts the pulse short, so that case is left out
  sequence s_pulse_half;
    !done_n_q [*2] ##1 done_n_q;
  endsequence
  AST_DONE_WIDTH: assert property (
    (evt_q && $past(pre_sel) == 2'h0 && !hold) |-> s_pulse_half)
    else $error("done pulse width wrong");
  AST_DONE_PULSE: assert property (
    $rose(evt_q) |-> !done_n_q)
    else $error("no done pulse at conversion end");
  AST_DONE_FLOAT: assert property (
    (done_n_q && !done_idle_drive_sel) |-> !conversion_done_oe)
    else $error("done drives while idle float chosen");
  AST_BITSTREAM: assert property (
    bitstream_out_enable |-> !conversion_done_oe)
    else $error("done driven with bitstream enabled");
  AST_SDO_QUIET: assert property (
    (spi && (st_q == ST_CMD || st_q == ST_WRITE)) |-> !sdo_oe)
    else $error("data out driven outside read");
  AST_CS_IDLE: assert property (
    (spi && s_cs_n) |=> st_q == ST_IDLE)
    else $error("traffic taken with chip select high");
  AST_RESET_BLOCK: assert property (
    hold |=> (st_q == ST_IDLE && !sdo_oe && done_n_q))
    else $error("activity during master reset");
  AST_STRAP_HOLD: assert property (
    !strap_cap |=> $stable(strap_q))
    else $error("strap changed outside capture");
  AST_MODE_HOLD: assert property (
    !mode_cap |=> $stable(mode_q))
    else $error("mode changed outside capture");
endmodule : afe_pin_if
`default_nettype wire

// *** verif/afe_spi_host.sv ***
// host side serial master model for the pin interface
`timescale 1ns/1ps
`default_nettype none
module afe_spi_host #(
  parameter int HALF = 6 // mclk cycles per sck level, slow for the oversampler
) (
  input wire logic mclk, // bench clock
  output logic cs_n, // chip select, active low
  output logic sck, // serial clock
  output logic sdi, // data to the device
  input wire logic sdo, // resolved data-out wire
  input wire logic sdo_oe // device drive enable, observed only
);
  // pins start deselected with the clock parked
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    sdi = 1'h0;
  end
  // hold static levels, used when these pins serve as straps
  task automatic park(input logic c, input logic d);
    @(negedge mclk);
    cs_n = c;
    sdi = d;
  endtask : park
  // one transfer of n bits, msb first; sel low keeps cs high throughout
  task automatic xfer(input logic cpol, input logic sel, input int n,
      input logic [79:0] tx, output logic [79:0] rx, output logic [79:0] oe);
    rx = '0;
    oe = '0;
    @(negedge mclk);
    sck = cpol; // idle level only moves while deselected
    repeat (HALF) @(negedge mclk);
    cs_n = !sel;
    repeat (HALF) @(negedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'h0; // device shifts out here
      sdi = tx[i]; // command byte then data bytes
      repeat (HALF) @(negedge mclk);
      rx[i] = sdo;
      oe[i] = sdo_oe;
      sck = 1'h1; // device samples here
      repeat (HALF) @(negedge mclk);
    end
    sck = cpol; // clock stands still outside frames
    repeat (HALF) @(negedge mclk);
    cs_n = 1'h1;
    sdi = !sdi; // released line keeps no stale level
    repeat (HALF) @(negedge mclk);
  endtask : xfer
endmodule : afe_spi_host
`default_nettype wire

// *** verif/afe_pin_if_tb_top.sv ***
// self-checking bench for the pin interface
`timescale 1ns/1ps
`default_nettype none
module afe_pin_if_tb_top;
  logic mclk, nrst, mrst, done_strap, clk_in, mode_pin, ext_sel, idle_sel;
  logic bs_en, wdt, tw_clk, res_valid, sdo_last;
  logic [1:0] pre;
  logic [2:0] osr;
  logic [23:0] res_data;
  wire [4:0] straps;
  wire [7:0] cmd_q, wr_q;
  logic [15:0] wr_log;
  logic [79:0] rx, oe;
  wire sdo_o, sdo_oe, done_n, done_oe, osc_en, res_ready, conv_evt;
  wire cmd_valid, wr_valid, two_wire, cs_n, sck_h, sdi, sdo_w, done_w, sck_w;
  int bad_count, checks_done, cmd_cnt, evt_cnt, cyc;
  // pin wires: released data line inverts, released done pin reads done_strap
  assign sdo_w = (sdo_oe === 1'h1) ? sdo_o : ~sdo_last;
  assign done_w = (done_oe === 1'h1) ? done_n : done_strap;
  assign sck_w = tw_clk ? mclk : sck_h; // continuous clock
  afe_pin_if #(.WORD_W(24)) DUT (.mclk(mclk), .nrst(nrst),
    .mreset_pin(mrst), .sck_pin(sck_w), .cs_n_pin(cs_n), .sdi_pin(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .done_pin_i(done_w),
    .conversion_done_n(done_n), .conversion_done_oe(done_oe),
    .clock_input_pin(clk_in), .crystal_return_pin(mode_pin),
    .external_clock_sel(ext_sel), .osc_enable(osc_en),
    .done_idle_drive_sel(idle_sel), .bitstream_out_enable(bs_en),
    .wdt_reset(wdt), .pre_sel(pre), .osr_sel(osr), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .conv_evt(conv_evt),
    .cmd_q(cmd_q), .cmd_valid(cmd_valid), .wr_byte_q(wr_q),
    .wr_byte_valid(wr_valid), .two_wire_mode(two_wire),
    .gain_strap_hi(straps[4]), .gain_strap_lo(straps[3]),
    .bias_strap_a(straps[2]), .ratio_strap_hi(straps[1]),
    .ratio_strap_lo(straps[0]));
  afe_spi_host host (.mclk(mclk), .cs_n(cs_n), .sck(sck_h), .sdi(sdi),
    .sdo(sdo_w), .sdo_oe(sdo_oe));
  // free-running bench clock, 25 ns
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  // one-cycle pulses are logged mid-cycle, where they are settled
  always @(negedge mclk) begin
    sdo_last <= (sdo_oe === 1'h1) ? sdo_o : sdo_last;
    if (wr_valid === 1'h1) wr_log = {wr_log[7:0], wr_q};
    if (cmd_valid === 1'h1) cmd_cnt++;
    if (conv_evt === 1'h1) evt_cnt++;
  end
  // cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [79:0] e,
      input logic [79:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic do_reset;
    nrst = 1'h0;
    repeat (12) @(negedge mclk);
    nrst = 1'h1;
    repeat (8) @(negedge mclk);
  endtask : do_reset
  // global ceiling bounds this wait
  task automatic wait_evt;
    @(negedge mclk);
    while (conv_evt !== 1'h1) @(negedge mclk);
  endtask : wait_evt
  // offer one word; ready is combinational so it is read before the edge
  task automatic push(input logic [23:0] w, output logic ok);
    @(negedge mclk);
    res_valid = 1'h1;
    res_data = w;
    #1 ok = res_ready;
    @(negedge mclk);
    res_valid = 1'h0;
  endtask : push
  // crystal versus external clock, mode pin read and then held
  task automatic t_clk_mode;
    chk("xtal", 2'h1, {two_wire, osc_en});
    ext_sel = 1'h1;
    mode_pin = 1'h0;
    do_reset();
    chk("ext_clk", 2'h0, {two_wire, osc_en});
    mode_pin = 1'h1;
    repeat (6) @(negedge mclk);
    chk("mode_held", 1'h0, two_wire);
    mode_pin = 1'h0;
    repeat (4) @(negedge mclk);
    $display("test clock mode done");
  endtask : t_clk_mode
  task automatic t_pulse;
    int w, p;
    for (int k = 0; k < 3; k++) begin
      pre = (k == 1) ? 2'h1 : 2'h0;
      osr = (k == 2) ? 3'h1 : 3'h0;
      idle_sel = 1'h1;
      wait_evt();
      wait_evt();
      w = 0;
      p = 0;
      while (done_n === 1'h0) begin
        w++;
        p++;
        @(negedge mclk);
      end
      chk("idle", 2'h3, {done_oe, done_n});
      while (conv_evt !== 1'h1) begin
        p++;
        @(negedge mclk);
      end
      chk("width", 2 << pre, w);
      chk("period", (128 << pre) << osr, p);
    end
    wait_evt();
    idle_sel = 1'h0;
    repeat (8) @(negedge mclk);
    chk("float", 1'h0, done_oe);
    idle_sel = 1'h1;
    bs_en = 1'h1;
    repeat (8) @(negedge mclk);
    chk("bs_off", 1'h0, done_oe);
    bs_en = 1'h0;
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_block;
    int c, e;
    c = cmd_cnt;
    host.xfer(1'h0, 1'h0, 16, 80'h41FF, rx, oe);
    chk("cs_hi", c, cmd_cnt);
    chk("cs_hi_oe", 80'h0, oe);
    mrst = 1'h0;
    repeat (4) @(negedge mclk);
    e = evt_cnt;
    host.xfer(1'h0, 1'h1, 16, 80'h41FF, rx, oe);
    chk("mrst", c, cmd_cnt);
    chk("mrst_oe", 80'h0, oe);
    chk("mrst_evt", e, evt_cnt);
    mrst = 1'h1;
    repeat (8) @(negedge mclk);
    $display("test block done");
  endtask : t_block
  task automatic t_rw;
    logic ok;
    push(24'hA1B2C3, ok);
    chk("push0", 1'h1, ok);
    push(24'h5D6E7F, ok);
    chk("push1", 1'h1, ok);
    push(24'h123456, ok);
    chk("full", 1'h0, ok);
    wr_log = '0;
    host.xfer(1'h0, 1'h1, 80, {8'h41, {9{8'hC3}}}, rx, oe);
    chk("rd_data", {24'hA1B2C3, 24'h5D6E7F, 24'h0}, rx[71:0]);
    chk("rd_oe", {8'h00, {72{1'h1}}}, oe);
    chk("rd_cmd", 8'h41, cmd_q);
    chk("rd_nowr", 16'h0, wr_log);
    host.xfer(1'h1, 1'h1, 24, {56'h0, 8'h40, 16'hA53C}, rx, oe);
    chk("wr_bytes", 16'hA53C, wr_log);
    chk("wr_cmd", 8'h40, cmd_q);
    chk("wr_oe", 80'h0, oe);
    $display("test read write done");
  endtask : t_rw
  task automatic t_two;
    logic ok;
    logic [23:0] f;
    mode_pin = 1'h1;
    host.park(1'h1, 1'h0);
    do_reset();
    tw_clk = 1'h1;
    repeat (8) @(negedge mclk);
    chk("tw_mode", 1'h1, two_wire);
    chk("straps", 5'h15, straps);
    chk("tw_done", 1'h0, done_oe);
    done_strap = 1'h0;
    clk_in = 1'h1;
    mrst = 1'h0;
    host.park(1'h0, 1'h1);
    repeat (8) @(negedge mclk);
    chk("held", 5'h15, straps);
    wdt = 1'h1;
    @(negedge mclk);
    wdt = 1'h0;
    repeat (8) @(negedge mclk);
    chk("wdt", 5'h0A, straps);
    chk("wdt_mode", 1'h1, two_wire);
    wait_evt();
    push(24'hC35A96, ok);
    wait_evt();
    @(negedge mclk);
    chk("fr_oe", 1'h1, sdo_oe);
    for (int i = 0; i < 24; i++) begin
      @(negedge mclk);
      f = {f[22:0], sdo_o};
    end
    chk("frame", 24'hC35A96, f);
    repeat (4) @(negedge mclk);
    chk("fr_end", 1'h0, sdo_oe);
    $display("test two-wire done");
  endtask : t_two
  // main sequence, all inputs valued at time zero
  initial begin
    {nrst, mrst, done_strap, clk_in, mode_pin, ext_sel} = 6'h1F;
    {idle_sel, bs_en, wdt, tw_clk, res_valid, sdo_last} = 6'h00;
    nrst = 1'h0;
    clk_in = 1'h0;
    pre = 2'h0;
    osr = 3'h0;
    res_data = 24'h0;
    ext_sel = 1'h0;
    wr_log = '0;
    do_reset();
    t_clk_mode();
    t_pulse();
    t_block();
    t_rw();
    t_two();
    complete_run();
  end
endmodule : afe_pin_if_tb_top
`default_nettype wire
